// [inc/mat_consts.svh]
// Notes on behaviour
// - Destination address lookup picks egress ports
// - Entries are static, dynamic or filter, address to ports
// - Source address learns or refreshes dynamic entries
// - Unrefreshed dynamic entries expire after aging time
// - Aging time accepted only from 10 to 630 s
// - Aging time resets to 300 seconds
// - Entry fields and kind readable by management
// - Enumeration ordered by VLAN, then address
// - Convert selected dynamic entry into static entry
// - Frames matching filter address and VLAN dropped
`ifndef MAT_CONSTS_SVH
`define MAT_CONSTS_SVH

`define MAT_DEPTH 16
`define MAT_NPORT 10
`define MAT_ADDR_W 8
`define MAT_MAC_W 48
`define MAT_VID_W 13
`define MAT_AGE_W 10

`define MAT_CLK_PERIOD_NS 100
`define MAT_SECOND_NS 1000000000

`define MAT_AGING_DEF 10'h12C
`define MAT_AGING_MIN 10'h00A
`define MAT_AGING_MAX 10'h276
`define MAT_VID_MIN 13'h0001
`define MAT_VID_MAX 13'h1000

`define MAT_OFS_AGING 8'h00
`define MAT_OFS_KEY_MAC_LO 8'h04
`define MAT_OFS_KEY_MAC_HI 8'h08
`define MAT_OFS_KEY_VID_PORTS 8'h0C
`define MAT_OFS_CMD 8'h10
`define MAT_OFS_RES_MAC_LO 8'h14
`define MAT_OFS_RES_INFO 8'h18
`define MAT_OFS_RES_VID_PORTS 8'h1C

`define MAT_PORTS_LSB 16
`define MAT_INFO_FOUND 16
`define MAT_INFO_STATIC 17
`define MAT_INFO_FILTER 18
`define MAT_CMD_ERR 0
`define MAT_CNT_LSB 8

`endif

// [inc/mat_pkg.sv]
package mat_pkg;

  typedef enum logic [2:0] {
    MAT_OP_NONE       = 3'h0,
    MAT_OP_ADD_STATIC = 3'h1,
    MAT_OP_ADD_FILTER = 3'h2,
    MAT_OP_DELETE     = 3'h3,
    MAT_OP_FLUSH      = 3'h4,
    MAT_OP_CONVERT    = 3'h5,
    MAT_OP_ENUM_GE    = 3'h6
  } mat_op_e;

  typedef enum logic [1:0] {
    MAT_RESP_OKAY   = 2'h0,
    MAT_RESP_SLVERR = 2'h2
  } mat_resp_e;

endpackage

// [inc/mat_reg_if.sv]
`timescale 1ns/1ps
`include "mat_consts.svh"
interface mat_reg_if;
  logic wr_en;
  logic [`MAT_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [`MAT_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface

// [src/mat_axil.sv]
`timescale 1ns/1ps
`include "mat_consts.svh"
module mat_axil import mat_pkg::*; (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Write address and data
  input wire logic axi_awvalid_in,
  input wire logic [`MAT_ADDR_W-1:0] axi_awaddr_in,
  output logic axi_awready_out,
  input wire logic axi_wvalid_in,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  output logic axi_wready_out,
  // Write response
  output logic axi_bvalid_out,
  output logic [1:0] axi_bresp_out,
  input wire logic axi_bready_in,
  // Read
  input wire logic axi_arvalid_in,
  input wire logic [`MAT_ADDR_W-1:0] axi_araddr_in,
  output logic axi_arready_out,
  output logic axi_rvalid_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  input wire logic axi_rready_in,
  // Register access toward the table
  mat_reg_if.bus rif
);
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [`MAT_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  wire aw_take = axi_awvalid_in & axi_awready_out;
  wire w_take = axi_wvalid_in & axi_wready_out;
  wire ar_take = axi_arvalid_in & axi_arready_out;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;

  assign axi_awready_out = ~aw_have_q & ~bvalid_q;
  assign axi_wready_out = ~w_have_q & ~bvalid_q;
  assign axi_arready_out = ~rvalid_q;
  assign axi_bvalid_out = bvalid_q;
  assign axi_bresp_out = bresp_q;
  assign axi_rvalid_out = rvalid_q;
  assign axi_rdata_out = rdata_q;
  assign axi_rresp_out = rresp_q;
  assign rif.wr_en = wr_go;
  assign rif.wr_addr = awaddr_q;
  assign rif.wr_data = wdata_q;
  assign rif.wr_strb = wstrb_q;
  assign rif.rd_addr = axi_araddr_in;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= MAT_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= axi_awaddr_in;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= axi_wdata_in;
        wstrb_q <= axi_wstrb_in;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= rif.wr_ok ? MAT_RESP_OKAY : MAT_RESP_SLVERR;
      end else if (axi_bready_in) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= MAT_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rif.rd_data;
      rresp_q <= rif.rd_ok ? MAT_RESP_OKAY : MAT_RESP_SLVERR;
    end else if (axi_rready_in) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule

// [src/mat_table.sv]
`timescale 1ns/1ps
`include "mat_consts.svh"
module mat_table import mat_pkg::*; #(
  parameter int unsigned DEPTH = `MAT_DEPTH,
  parameter int unsigned NPORT = `MAT_NPORT,
  parameter int unsigned PW = $clog2(NPORT),
  parameter int unsigned SEC_CYCLES = `MAT_SECOND_NS / `MAT_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // AXI4-Lite write
  input wire logic axi_awvalid_in,
  input wire logic [`MAT_ADDR_W-1:0] axi_awaddr_in,
  output logic axi_awready_out,
  input wire logic axi_wvalid_in,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  output logic axi_wready_out,
  output logic axi_bvalid_out,
  output logic [1:0] axi_bresp_out,
  input wire logic axi_bready_in,
  // AXI4-Lite read
  input wire logic axi_arvalid_in,
  input wire logic [`MAT_ADDR_W-1:0] axi_araddr_in,
  output logic axi_arready_out,
  output logic axi_rvalid_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  input wire logic axi_rready_in,
  // Frame presented by port receive logic
  input wire logic frm_valid_in,
  input wire logic [`MAT_MAC_W-1:0] frm_destination_station_address_in,
  input wire logic [`MAT_MAC_W-1:0] frm_source_station_address_in,
  input wire logic [`MAT_VID_W-1:0] frm_vid_in,
  input wire logic [PW-1:0] frm_ingress_in,
  // Forwarding decision
  output logic fwd_valid_out,
  output logic [NPORT-1:0] fwd_ports_out,
  output logic fwd_known_out,
  output logic fwd_drop_out
);
  localparam int unsigned IW = $clog2(DEPTH);
  localparam int unsigned TW = $clog2(SEC_CYCLES);
  localparam int unsigned KW = `MAT_VID_W + `MAT_MAC_W;

  mat_reg_if rif ();

  mat_axil u_axil (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .axi_awvalid_in(axi_awvalid_in),
    .axi_awaddr_in(axi_awaddr_in),
    .axi_awready_out(axi_awready_out),
    .axi_wvalid_in(axi_wvalid_in),
    .axi_wdata_in(axi_wdata_in),
    .axi_wstrb_in(axi_wstrb_in),
    .axi_wready_out(axi_wready_out),
    .axi_bvalid_out(axi_bvalid_out),
    .axi_bresp_out(axi_bresp_out),
    .axi_bready_in(axi_bready_in),
    .axi_arvalid_in(axi_arvalid_in),
    .axi_araddr_in(axi_araddr_in),
    .axi_arready_out(axi_arready_out),
    .axi_rvalid_out(axi_rvalid_out),
    .axi_rdata_out(axi_rdata_out),
    .axi_rresp_out(axi_rresp_out),
    .axi_rready_in(axi_rready_in),
    .rif(rif)
  );

  // Table storage, one slot per entry
  logic [DEPTH-1:0] vld_q, vld_d, stat_q, stat_d, filt_q, filt_d;
  logic [`MAT_MAC_W-1:0] mac_q [DEPTH];
  logic [`MAT_MAC_W-1:0] mac_d [DEPTH];
  logic [`MAT_VID_W-1:0] vid_q [DEPTH];
  logic [`MAT_VID_W-1:0] vid_d [DEPTH];
  logic [NPORT-1:0] prt_q [DEPTH];
  logic [NPORT-1:0] prt_d [DEPTH];
  logic [`MAT_AGE_W-1:0] age_q [DEPTH];
  logic [`MAT_AGE_W-1:0] age_d [DEPTH];
  logic [KW-1:0] ekey [DEPTH];

  // Management registers, aging prescaler and forwarding decision registers
  logic [`MAT_AGE_W-1:0] aging_q;
  logic [`MAT_MAC_W-1:0] key_mac_q;
  logic [`MAT_VID_W-1:0] key_vid_q;
  logic [NPORT-1:0] key_prt_q;
  logic err_q, res_found_q;
  logic [IW-1:0] res_idx_q;
  logic [TW-1:0] pre_q;
  logic fwd_valid_q, fwd_known_q, fwd_drop_q;
  logic [NPORT-1:0] fwd_ports_q;

  // Per-entry match vectors
  logic [DEPTH-1:0] dst_hit, src_hit, flt_hit, key_hit, key_ge, dyn;
  logic [NPORT-1:0] dst_ports;
  logic best_any;
  logic [IW-1:0] best_idx;

  wire [KW-1:0] key_all = {key_vid_q, key_mac_q};
  wire [NPORT-1:0] ing_oh = NPORT'(1) << frm_ingress_in;
  wire tick = (pre_q == TW'(SEC_CYCLES - 1));

  // Register write decode
  wire wr_aging = rif.wr_en & (rif.wr_addr == `MAT_OFS_AGING);
  wire wr_klo = rif.wr_en & (rif.wr_addr == `MAT_OFS_KEY_MAC_LO);
  wire wr_khi = rif.wr_en & (rif.wr_addr == `MAT_OFS_KEY_MAC_HI);
  wire wr_kvp = rif.wr_en & (rif.wr_addr == `MAT_OFS_KEY_VID_PORTS);
  wire cmd_wr = rif.wr_en & (rif.wr_addr == `MAT_OFS_CMD) & rif.wr_strb[0];
  wire [`MAT_AGE_W-1:0] aging_new = rif.wr_data[`MAT_AGE_W-1:0];
  wire aging_ok = (aging_new >= `MAT_AGING_MIN) && (aging_new <= `MAT_AGING_MAX);
  wire aging_take = wr_aging & (&rif.wr_strb[1:0]) & aging_ok;
  wire [2:0] op_raw = rif.wr_data[2:0];
  wire vid_ok = (key_vid_q >= `MAT_VID_MIN) && (key_vid_q <= `MAT_VID_MAX);

  wire slot_ok = (|key_hit) | ~(&vld_q);
  wire [DEPTH-1:0] free_sel = ~vld_q & (vld_q + DEPTH'(1));
  wire [DEPTH-1:0] key_sel = key_hit & (~key_hit + DEPTH'(1));
  wire [DEPTH-1:0] wr_sel = (|key_hit) ? key_sel : free_sel;

  wire op_st = cmd_wr & (op_raw == MAT_OP_ADD_STATIC) & slot_ok;
  wire op_ft = cmd_wr & (op_raw == MAT_OP_ADD_FILTER) & slot_ok & vid_ok;
  wire op_del = cmd_wr & (op_raw == MAT_OP_DELETE);
  wire op_flush = cmd_wr & (op_raw == MAT_OP_FLUSH);
  wire op_conv = cmd_wr & (op_raw == MAT_OP_CONVERT);
  wire op_enum = cmd_wr & (op_raw == MAT_OP_ENUM_GE);
  wire op_fail = (cmd_wr & (op_raw == MAT_OP_ADD_STATIC) & ~slot_ok)
    | (cmd_wr & (op_raw == MAT_OP_ADD_FILTER) & ~(slot_ok & vid_ok))
    | (op_del & ~(|key_hit)) | (op_conv & ~(|(key_hit & dyn)));

  // Learning is held off while a management command rewrites the table
  wire lrn_ok = frm_valid_in & ~cmd_wr & ~(|flt_hit) & ~(|(src_hit & stat_q));
  wire [DEPTH-1:0] lrn_ref = lrn_ok ? (src_hit & dyn) : '0;
  wire [DEPTH-1:0] lrn_new = (lrn_ok & ~(|src_hit)) ? free_sel : '0;

  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_ent
    assign ekey[i] = {vid_q[i], mac_q[i]};
    assign dyn[i] = vld_q[i] & ~stat_q[i] & ~filt_q[i];
    assign dst_hit[i] = vld_q[i] & ~filt_q[i] & (vid_q[i] == frm_vid_in)
      & (mac_q[i] == frm_destination_station_address_in);
    assign src_hit[i] = vld_q[i] & ~filt_q[i] & (vid_q[i] == frm_vid_in)
      & (mac_q[i] == frm_source_station_address_in);
    assign flt_hit[i] = vld_q[i] & filt_q[i] & (vid_q[i] == frm_vid_in)
      & ((mac_q[i] == frm_source_station_address_in)
      | (mac_q[i] == frm_destination_station_address_in));
    assign key_hit[i] = vld_q[i] & (ekey[i] == key_all);
    assign key_ge[i] = vld_q[i] & (ekey[i] >= key_all);

    always_comb begin
      vld_d[i] = vld_q[i];
      stat_d[i] = stat_q[i];
      filt_d[i] = filt_q[i];
      mac_d[i] = mac_q[i];
      vid_d[i] = vid_q[i];
      prt_d[i] = prt_q[i];
      age_d[i] = age_q[i];
      if ((op_st | op_ft) & wr_sel[i]) begin
        vld_d[i] = 1'b1;
        stat_d[i] = op_st;
        filt_d[i] = op_ft;
        mac_d[i] = key_mac_q;
        vid_d[i] = key_vid_q;
        prt_d[i] = op_ft ? '0 : key_prt_q;
        age_d[i] = '0;
      end else if (op_del & key_hit[i]) begin
        vld_d[i] = 1'b0;
      end else if (op_flush & dyn[i]) begin
        vld_d[i] = 1'b0;
      end else if (op_conv & key_hit[i] & dyn[i]) begin
        stat_d[i] = 1'b1;
      end else if (lrn_ref[i]) begin
        age_d[i] = '0;
        prt_d[i] = ing_oh;
      end else if (lrn_new[i]) begin
        vld_d[i] = 1'b1;
        stat_d[i] = 1'b0;
        filt_d[i] = 1'b0;
        mac_d[i] = frm_source_station_address_in;
        vid_d[i] = frm_vid_in;
        prt_d[i] = ing_oh;
        age_d[i] = '0;
      end else if (tick & dyn[i]) begin
        if (age_q[i] + `MAT_AGE_W'(1) >= aging_q) begin
          vld_d[i] = 1'b0;
        end else begin
          age_d[i] = age_q[i] + `MAT_AGE_W'(1);
        end
      end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
        vld_q[i] <= 1'b0;
        stat_q[i] <= 1'b0;
        filt_q[i] <= 1'b0;
        mac_q[i] <= '0;
        vid_q[i] <= '0;
        prt_q[i] <= '0;
        age_q[i] <= '0;
      end else begin
        vld_q[i] <= vld_d[i];
        stat_q[i] <= stat_d[i];
        filt_q[i] <= filt_d[i];
        mac_q[i] <= mac_d[i];
        vid_q[i] <= vid_d[i];
        prt_q[i] <= prt_d[i];
        age_q[i] <= age_d[i];
      end
    end
  end

  always_comb begin
    dst_ports = '0;
    best_any = 1'b0;
    best_idx = '0;
    for (int k = 0; k < DEPTH; k++) begin
      if (dst_hit[k]) begin
        dst_ports = dst_ports | prt_q[k];
      end
      if (key_ge[k] && (!best_any || ekey[k] < ekey[best_idx])) begin
        best_any = 1'b1;
        best_idx = IW'(k);
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fwd_valid_q <= 1'b0;
      fwd_known_q <= 1'b0;
      fwd_drop_q <= 1'b0;
      fwd_ports_q <= '0;
    end else begin
      fwd_valid_q <= frm_valid_in;
      fwd_known_q <= frm_valid_in & (|dst_hit);
      fwd_drop_q <= frm_valid_in & (|flt_hit);
      fwd_ports_q <= ~frm_valid_in ? '0 : (|dst_hit) ? dst_ports : ~ing_oh;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      aging_q <= `MAT_AGING_DEF;
      pre_q <= '0;
    end else begin
      pre_q <= tick ? '0 : pre_q + TW'(1);
      if (aging_take) begin
        aging_q <= aging_new;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      key_mac_q <= '0;
      key_vid_q <= '0;
      key_prt_q <= '0;
    end else begin
      if (wr_klo) begin
        key_mac_q[31:0] <= rif.wr_data;
      end
      if (wr_khi) begin
        key_mac_q[47:32] <= rif.wr_data[15:0];
      end
      if (wr_kvp) begin
        key_vid_q <= rif.wr_data[`MAT_VID_W-1:0];
        key_prt_q <= rif.wr_data[`MAT_PORTS_LSB +: NPORT];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      err_q <= 1'b0;
      res_found_q <= 1'b0;
      res_idx_q <= '0;
    end else begin
      if (cmd_wr) begin
        err_q <= op_fail | (wr_aging & ~aging_ok);
      end else if (wr_aging) begin
        err_q <= ~aging_ok;
      end
      if (op_enum) begin
        res_found_q <= best_any;
        res_idx_q <= best_idx;
      end
    end
  end

  // Register read selection
  wire [31:0] rd_cmd = {16'h0000, 8'(unsigned'($countones(vld_q))), 7'h00, err_q};
  wire [31:0] rd_info = {13'h0000, filt_q[res_idx_q], stat_q[res_idx_q], res_found_q,
    mac_q[res_idx_q][47:32]};
  wire [31:0] rd_rvp = 32'({prt_q[res_idx_q], 3'h0, vid_q[res_idx_q]});
  wire [31:0] rd_kvp = 32'({key_prt_q, 3'h0, key_vid_q});
  assign rif.rd_ok = (rif.rd_addr[1:0] == 2'h0) && (rif.rd_addr <= `MAT_OFS_RES_VID_PORTS);
  assign rif.wr_ok = (rif.wr_addr[1:0] == 2'h0) && (rif.wr_addr <= `MAT_OFS_RES_VID_PORTS);
  assign rif.rd_data =
    (rif.rd_addr == `MAT_OFS_AGING) ? 32'(aging_q) :
    (rif.rd_addr == `MAT_OFS_KEY_MAC_LO) ? key_mac_q[31:0] :
    (rif.rd_addr == `MAT_OFS_KEY_MAC_HI) ? {16'h0000, key_mac_q[47:32]} :
    (rif.rd_addr == `MAT_OFS_KEY_VID_PORTS) ? rd_kvp :
    (rif.rd_addr == `MAT_OFS_CMD) ? rd_cmd :
    (rif.rd_addr == `MAT_OFS_RES_MAC_LO) ? mac_q[res_idx_q][31:0] :
    (rif.rd_addr == `MAT_OFS_RES_INFO) ? rd_info :
    (rif.rd_addr == `MAT_OFS_RES_VID_PORTS) ? rd_rvp : 32'h0000_0000;

  assign fwd_valid_out = fwd_valid_q;
  assign fwd_known_out = fwd_known_q;
  assign fwd_drop_out = fwd_drop_q;
  assign fwd_ports_out = fwd_ports_q;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  chk_aging_range: assert property (aging_q >= `MAT_AGING_MIN && aging_q <= `MAT_AGING_MAX)
    else $error("aging time left its legal range");
  chk_aging_hold: assert property (!aging_take |=> $stable(aging_q))
    else $error("aging time changed without an accepted write");
  chk_fwd_known: assert property (frm_valid_in && (|dst_hit) |=> fwd_known_out
    && fwd_ports_out == $past(dst_ports))
    else $error("known destination not forwarded to its ports");
  chk_learn_grow: assert property (lrn_ok && !(|src_hit) && !(&vld_q) && !tick
    |=> $countones(vld_q) == $countones($past(vld_q)) + 1)
    else $error("new source address not learned");
  chk_age_remove: assert property (|($past(dyn) & ~vld_q) |-> $past(tick) || $past(cmd_wr))
    else $error("dynamic entry vanished outside aging or command");
  chk_static_keep: assert property (|($past(stat_q & vld_q) & ~(stat_q & vld_q))
    |-> $past(op_del))
    else $error("static entry removed without delete");
  chk_flush_dyn: assert property (op_flush |=> dyn == '0
    && (stat_q & vld_q) == $past(stat_q & vld_q) && (filt_q & vld_q) == $past(filt_q & vld_q))
    else $error("flush left dynamic entries");
  chk_filter_drop: assert property (frm_valid_in && (|flt_hit) |=> fwd_drop_out)
    else $error("filtered frame not dropped");
  chk_convert_static: assert property (op_conv && (|(key_hit & dyn))
    |=> $countones(stat_q) == $countones($past(stat_q)) + 1)
    else $error("convert did not make the entry static");
  chk_enum_order: assert property (op_enum |=> !res_found_q
    || {vid_q[res_idx_q], mac_q[res_idx_q]} >= key_all)
    else $error("enumeration returned a smaller key");

  cov_learn: cover property (frm_valid_in && (|lrn_new) ##1 fwd_valid_out);
  cov_age_out: cover property (tick && (|dyn) ##1 !(|dyn));
  cov_filter: cover property (op_ft ##[1:20] fwd_drop_out);
  cov_convert: cover property (op_conv && (|(key_hit & dyn)));
endmodule

// [sim/mat_port_model.sv]
`timescale 1ns/1ps
`include "mat_consts.svh"
module mat_port_model (
  // Clock
  input wire logic clock_in,
  // Frame toward the table
  output logic frm_valid_out,
  output logic [`MAT_MAC_W-1:0] dst_out,
  output logic [`MAT_MAC_W-1:0] src_out,
  output logic [`MAT_VID_W-1:0] vid_out,
  output logic [3:0] ing_out,
  // Forwarding decision
  input wire logic fwd_valid_in,
  input wire logic [`MAT_NPORT-1:0] fwd_ports_in,
  input wire logic fwd_known_in,
  input wire logic fwd_drop_in
);
  initial begin
    frm_valid_out = 1'b0;
    dst_out = '0;
    src_out = '0;
    vid_out = '0;
    ing_out = '0;
  end
  // One-cycle frame; fields are inverted afterwards so stale values never match
  task automatic send(input logic [47:0] dst, input logic [47:0] src,
                      input logic [12:0] vid, input logic [3:0] ing, output logic [12:0] res);
    frm_valid_out <= 1'b1;
    dst_out <= dst;
    src_out <= src;
    vid_out <= vid;
    ing_out <= ing;
    @(posedge clock_in);
    frm_valid_out <= 1'b0;
    dst_out <= ~dst;
    src_out <= ~src;
    vid_out <= ~vid;
    ing_out <= ~ing;
    @(posedge clock_in);
    res = {fwd_valid_in, fwd_known_in, fwd_drop_in, fwd_ports_in};
  endtask
endmodule

// [sim/mac_address_table_tb_top.sv]
`timescale 1ns/1ps
`include "mat_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module mac_address_table_tb_top import mat_pkg::*;;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, fvld, fknown, fdrop, frm_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] fports;
  logic [47:0] fdst, fsrc;
  logic [12:0] fvid;
  logic [3:0] fing;
  int mismatches = 0;
  int cmp_count = 0;
  always #50 clock_in = ~clock_in;
  mat_table #(.SEC_CYCLES(20)) mat_table_inst (.clock_in(clock_in), .rstn_in(rstn_in),
    .axi_awvalid_in(awvalid), .axi_awaddr_in(awaddr), .axi_awready_out(awready),
    .axi_wvalid_in(wvalid), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
    .axi_wready_out(wready), .axi_bvalid_out(bvalid), .axi_bresp_out(bresp),
    .axi_bready_in(1'b1), .axi_arvalid_in(arvalid), .axi_araddr_in(araddr),
    .axi_arready_out(arready), .axi_rvalid_out(rvalid), .axi_rdata_out(rdata),
    .axi_rresp_out(rresp), .axi_rready_in(1'b1), .frm_valid_in(frm_valid),
    .frm_destination_station_address_in(fdst), .frm_source_station_address_in(fsrc),
    .frm_vid_in(fvid), .frm_ingress_in(fing), .fwd_valid_out(fvld),
    .fwd_ports_out(fports), .fwd_known_out(fknown), .fwd_drop_out(fdrop));
  mat_port_model mat_port_model_inst (.clock_in(clock_in), .frm_valid_out(frm_valid),
    .dst_out(fdst), .src_out(fsrc), .vid_out(fvid), .ing_out(fing), .fwd_valid_in(fvld),
    .fwd_ports_in(fports), .fwd_known_in(fknown), .fwd_drop_in(fdrop));

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo;
    mismatches++;
    $display("MISMATCH bus wait exp answer got none");
    close_out();
  endtask
  // Response ready is held high throughout, so bvalid/rvalid end each access
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) tmo();
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    arvalid <= 1'b1;
    araddr <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) tmo();
    d = rdata;
    r = rresp;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [12:0] v, input logic [47:0] m,
                     input logic [9:0] p);
    logic [1:0] r;
    wr(8'h04, m[31:0], r);
    wr(8'h08, {16'h0000, m[47:32]}, r);
    wr(8'h0C, {6'h00, p, 3'h0, v}, r);
    wr(8'h10, {29'h0000000, op}, r);
    `CHK("cmd resp", 2'h0, r)
  endtask
  task automatic st(input logic e, input logic [7:0] c);
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h10, d, r);
    `CHK("status", {e, c}, {d[0], d[15:8]})
  endtask
  task automatic fr(input logic [47:0] ds, input logic [47:0] sr, input logic [12:0] v,
                    input logic [3:0] i, input logic [12:0] e, input logic [12:0] m);
    logic [12:0] res;
    mat_port_model_inst.send(ds, sr, v, i, res);
    `CHK("forward", e & m, res & m)
  endtask
  task automatic en(input logic [12:0] kv, input logic [47:0] km, input logic [12:0] v,
                    input logic [47:0] m, input logic [2:0] i, input logic [9:0] p);
    logic [31:0] d;
    logic [1:0] r;
    cmd(3'h6, kv, km, 10'h000);
    rd(8'h14, d, r);
    `CHK("res mac", m[31:0], d)
    rd(8'h18, d, r);
    `CHK("res info", {i[2], i[0], m[47:32]}, {d[18], d[16], d[15:0]})
    `CHK("res static", i[1], d[17])
    rd(8'h1C, d, r);
    `CHK("res vid ports", {p, v}, {d[25:16], d[12:0]})
  endtask

  task automatic t_aging_cfg;
    logic [9:0] val[4] = '{10'h009, 10'h00A, 10'h276, 10'h277};
    logic [9:0] age[4] = '{10'h12C, 10'h00A, 10'h276, 10'h276};
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h00, d, r);
    `CHK("aging reset", 10'h12C, d[9:0])
    st(1'b0, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {22'h000000, val[k]}, r);
      st(val[k] == 10'h009 || val[k] == 10'h277, 8'h00);
      rd(8'h00, d, r);
      `CHK("aging", age[k], d[9:0])
    end
    wr(8'h20, 32'h00000001, r);
    `CHK("unmapped wr", 2'h2, r)
    rd(8'h24, d, r);
    `CHK("unmapped rd", 2'h2, r)
    $display("aging config test done");
  endtask
  task automatic t_learn_static_filter;
    fr(48'h30, 48'h20, 13'h0001, 4'h3, {3'b100, 10'h3F7}, 13'h1FFF);
    fr(48'h20, 48'h30, 13'h0001, 4'h7, {3'b110, 10'h008}, 13'h1FFF);
    cmd(3'h1, 13'h0002, 48'h10, 10'h0F0);
    fr(48'h10, 48'h10, 13'h0002, 4'h0, {3'b110, 10'h0F0}, 13'h1FFF);
    fr(48'h10, 48'h10, 13'h0002, 4'h1, {3'b110, 10'h0F0}, 13'h1FFF);
    st(1'b0, 8'h03);
    cmd(3'h2, 13'h0003, 48'h05, 10'h000);
    fr(48'h05, 48'h30, 13'h0003, 4'h7, {3'b101, 10'h000}, 13'h1400);
    st(1'b0, 8'h04);
    cmd(3'h2, 13'h0000, 48'h06, 10'h000);
    st(1'b1, 8'h04);
    $display("learn static filter test done");
  endtask
  task automatic t_enum_convert_flush;
    en(13'h0000, 48'h00, 13'h0001, 48'h20, 3'b001, 10'h008);
    en(13'h0001, 48'h21, 13'h0001, 48'h30, 3'b001, 10'h080);
    en(13'h0001, 48'h31, 13'h0002, 48'h10, 3'b011, 10'h0F0);
    en(13'h0002, 48'h11, 13'h0003, 48'h05, 3'b101, 10'h000);
    cmd(3'h5, 13'h0001, 48'h20, 10'h000);
    en(13'h0001, 48'h20, 13'h0001, 48'h20, 3'b011, 10'h008);
    cmd(3'h4, 13'h0000, 48'h00, 10'h000);
    st(1'b0, 8'h03);
    en(13'h0001, 48'h21, 13'h0002, 48'h10, 3'b011, 10'h0F0);
    $display("enum convert flush test done");
  endtask
  task automatic t_age_out;
    logic [1:0] r;
    wr(8'h00, 32'h0000000A, r);
    fr(48'h20, 48'h30, 13'h0001, 4'h7, {3'b110, 10'h008}, 13'h1FFF);
    st(1'b0, 8'h04);
    repeat (140) @(posedge clock_in);
    st(1'b0, 8'h04);
    repeat (80) @(posedge clock_in);
    st(1'b0, 8'h03);
    cmd(3'h3, 13'h0002, 48'h10, 10'h000);
    st(1'b0, 8'h02);
    fr(48'h10, 48'h40, 13'h0002, 4'h0, {3'b100, 10'h3FE}, 13'h1FFF);
    cmd(3'h3, 13'h0002, 48'h10, 10'h000);
    st(1'b1, 8'h03);
    $display("age out test done");
  endtask

  initial begin
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    t_aging_cfg();
    t_learn_static_filter();
    t_enum_convert_flush();
    t_age_out();
    close_out();
  end
endmodule
